// >>> inc/dgpio_pkg.sv
// dgpio_pkg: register map, field positions, reset values for the dual gpio port
// assumes: an 8-bit cpu register port with one-cycle read latency
package dgpio_pkg;
  // register offsets
  localparam logic [3:0] DGPIO_OFF_P0_DATA = 4'h0;
  localparam logic [3:0] DGPIO_OFF_P0_DIR = 4'h1;
  localparam logic [3:0] DGPIO_OFF_P1_DATA = 4'h2;
  localparam logic [3:0] DGPIO_OFF_P1_DIR = 4'h3;
  localparam logic [3:0] DGPIO_OFF_P1_FSEL = 4'h4;
  localparam logic [3:0] DGPIO_OFF_RT_CTRL = 4'h5;
  localparam logic [3:0] DGPIO_OFF_RT_BUF = 4'h6;
  localparam logic [3:0] DGPIO_OFF_PULLUP = 4'h7;
  // field positions
  localparam int DGPIO_RT_LOW_BIT = 0;
  localparam int DGPIO_RT_HIGH_BIT = 1;
  localparam int DGPIO_PU0_BIT = 0;
  localparam int DGPIO_PU1_BIT = 1;
  localparam int DGPIO_FSEL_PIN2 = 2;
  localparam int DGPIO_FSEL_PIN3 = 3;
  localparam int DGPIO_FSEL_PIN4 = 4;
  // control and mask values
  localparam logic [7:0] DGPIO_DIR_RESET = 8'hff;
  localparam logic [7:0] DGPIO_ZERO_RESET = 8'h00;
  localparam logic [7:0] DGPIO_FSEL_MASK = 8'h1c;
  localparam logic [7:0] DGPIO_PU_MASK = 8'h7f;
  localparam logic [7:0] DGPIO_RT_MASK = 8'h03;
  // register select codes
  typedef enum logic [3:0] {
    DGPIO_SEL_NONE = 4'h8,
    DGPIO_SEL_P0 = 4'h0,
    DGPIO_SEL_P1 = 4'h2
  } dgpio_sel_t;
endpackage

// >>> src/dgpio_port.sv
// dgpio_port: two 8-bit gpio ports, port 0 with realtime nibble output,
// port 1 pins 2..4 shareable with a serial unit
// assumes: cpu strobes are one cycle, read data valid the next cycle only;
// pad logic resolves pins from the active-low output enables
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module dgpio_port
  import dgpio_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // cpu register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // port 0 pins
  input wire logic [7:0] p0_pin_in,
  output logic [7:0] p0_pin_out,
  output logic [7:0] p0_pin_oe_n,
  output logic [7:0] p0_pullup_en,
  // port 1 pins
  input wire logic [7:0] p1_pin_in,
  output logic [7:0] p1_pin_out,
  output logic [7:0] p1_pin_oe_n,
  output logic [7:0] p1_pullup_en,
  // realtime output trigger
  input wire logic rt_trigger,
  // serial unit side
  input wire logic serial_shift_clock_out,
  input wire logic serial_shift_clock_oe,
  input wire logic serial_data_out,
  output logic serial_shift_clock,
  output logic serial_data_in
);
  // registers
  logic [7:0] p0_latch_r;
  logic [7:0] p0_latch_nxt;
  logic [7:0] p0_dir_r;
  logic [7:0] p1_latch_r;
  logic [7:0] p1_dir_r;
  logic [7:0] p1_fsel_r;
  logic [7:0] rt_ctrl_r;
  logic [7:0] rt_buf_r;
  logic [7:0] pullup_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] p0_out_r;
  logic [7:0] p0_oe_n_r;
  logic [7:0] p0_pu_r;
  logic [7:0] p1_out_r;
  logic [7:0] p1_oe_n_r;
  logic [7:0] p1_pu_r;
  logic sck_r;
  logic sdi_r;
  // decode wires
  logic [7:0] p0_level;
  logic [7:0] p1_level;
  logic [7:0] rt_mask;
  logic [7:0] p1_ctrl;
  logic [7:0] p1_ctrl_sig;
  logic [7:0] p0_read;
  logic [7:0] p1_read;
  logic [7:0] p0_oe_n_nxt;
  logic [7:0] p1_oe_n_nxt;
  logic [7:0] p1_out_nxt;
  logic wr_p0;
  logic wr_rtbuf;

  // pin levels pass the three-stage synchroniser before any read path
  dgpio_sync u_sync0 (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(p0_pin_in),
    .level_out(p0_level)
  );
  dgpio_sync u_sync1 (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(p1_pin_in),
    .level_out(p1_level)
  );

  // bit-select helper: expand one nibble enable into four mask bits
  function automatic logic [7:0] dgpio_nib_mask(input logic lo, input logic hi);
    dgpio_nib_mask = {{4{hi}}, {4{lo}}};
  endfunction

  // realtime masks; both nibbles set means the byte-wide group
  assign rt_mask = dgpio_nib_mask(rt_ctrl_r[DGPIO_RT_LOW_BIT],
                                  rt_ctrl_r[DGPIO_RT_HIGH_BIT]);
  assign wr_p0 = reg_wr && (reg_addr == DGPIO_OFF_P0_DATA);
  assign wr_rtbuf = reg_wr && (reg_addr == DGPIO_OFF_RT_BUF);

  // latch write: cpu writes land on all non-realtime bits, whatever the direction, unless a trigger comes in the same cycle;
  // realtime bits take the buffer on a trigger instead
  assign p0_latch_nxt = rt_trigger ? ((p0_latch_r & ~rt_mask) | (rt_buf_r & rt_mask)) :
                        wr_p0 ? ((reg_wdata & ~rt_mask) | (p0_latch_r & rt_mask)) :
                        p0_latch_r;

  // port 0 drive: realtime nibbles force the buffer on
  assign p0_oe_n_nxt = p0_dir_r & ~rt_mask;

  // port 1 control mode bits
  assign p1_ctrl = p1_fsel_r & DGPIO_FSEL_MASK;
  assign p1_ctrl_sig = {3'h0, serial_data_out, sdi_r, serial_shift_clock_out, 2'h0};
  // pin2 driven only when the serial unit drives its clock, pin3 input, pin4 output
  assign p1_oe_n_nxt = (p1_dir_r & ~p1_ctrl) |
                       {3'h0, 1'b0, p1_ctrl[DGPIO_FSEL_PIN3], ~serial_shift_clock_oe &
                        p1_ctrl[DGPIO_FSEL_PIN2], 2'h0};
  assign p1_out_nxt = (p1_latch_r & ~p1_ctrl) | (p1_ctrl_sig & p1_ctrl);

  // read paths: output bits give the latch, input bits the pin; a realtime
  // bit returns its latch; no path exists from an input bit's latch
  assign p0_read = ((p0_latch_r & (~p0_dir_r | rt_mask)) |
                    (p0_level & p0_dir_r & ~rt_mask));
  // control bits: pin level when dir is 1, internal signal when dir is 0
  assign p1_read = (p1_latch_r & ~p1_dir_r & ~p1_ctrl) |
                   (p1_level & p1_dir_r) |
                   (p1_ctrl_sig & ~p1_dir_r & p1_ctrl);

  // read mux; unmapped offsets read zero
  always_comb begin
    case (reg_addr)
      DGPIO_OFF_P0_DATA: rdata_nxt = p0_read;
      DGPIO_OFF_P0_DIR: rdata_nxt = p0_dir_r;
      DGPIO_OFF_P1_DATA: rdata_nxt = p1_read;
      DGPIO_OFF_P1_DIR: rdata_nxt = p1_dir_r;
      DGPIO_OFF_P1_FSEL: rdata_nxt = p1_fsel_r;
      DGPIO_OFF_RT_CTRL: rdata_nxt = rt_ctrl_r;
      DGPIO_OFF_RT_BUF: rdata_nxt = rt_buf_r;
      DGPIO_OFF_PULLUP: rdata_nxt = pullup_r;
      default: rdata_nxt = DGPIO_ZERO_RESET;
    endcase
  end

  // latches have no reset value that software may rely on; zero is chosen
  // a bit instruction arrives here as an ordinary 8-bit write of the merged byte
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      p0_latch_r <= DGPIO_ZERO_RESET;
      p1_latch_r <= DGPIO_ZERO_RESET;
    end else begin
      p0_latch_r <= p0_latch_nxt;
      if (reg_wr && reg_addr == DGPIO_OFF_P1_DATA) begin
        p1_latch_r <= reg_wdata;
      end
    end
  end

  // control registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      p0_dir_r <= DGPIO_DIR_RESET;
      p1_dir_r <= DGPIO_DIR_RESET;
      p1_fsel_r <= DGPIO_ZERO_RESET;
      rt_ctrl_r <= DGPIO_ZERO_RESET;
      rt_buf_r <= DGPIO_ZERO_RESET;
      pullup_r <= DGPIO_ZERO_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        DGPIO_OFF_P0_DIR: p0_dir_r <= reg_wdata;
        DGPIO_OFF_P1_DIR: p1_dir_r <= reg_wdata;
        DGPIO_OFF_P1_FSEL: p1_fsel_r <= reg_wdata & DGPIO_FSEL_MASK;
        DGPIO_OFF_RT_CTRL: rt_ctrl_r <= reg_wdata & DGPIO_RT_MASK;
        DGPIO_OFF_PULLUP: pullup_r <= reg_wdata & DGPIO_PU_MASK;
        default: rt_buf_r <= wr_rtbuf ? reg_wdata : rt_buf_r;
      endcase
    end
  end

  // registered outputs; pin drive lags the control state by one cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_r <= DGPIO_ZERO_RESET;
      p0_out_r <= DGPIO_ZERO_RESET;
      p0_oe_n_r <= DGPIO_DIR_RESET;
      p0_pu_r <= DGPIO_ZERO_RESET;
      p1_out_r <= DGPIO_ZERO_RESET;
      p1_oe_n_r <= DGPIO_DIR_RESET;
      p1_pu_r <= DGPIO_ZERO_RESET;
      sck_r <= 1'b0;
      sdi_r <= 1'b0;
    end else begin
      rdata_r <= reg_rd ? rdata_nxt : DGPIO_ZERO_RESET;
      p0_out_r <= p0_latch_r;
      p0_oe_n_r <= p0_oe_n_nxt;
      p0_pu_r <= p0_dir_r & {8{pullup_r[DGPIO_PU0_BIT]}};
      p1_out_r <= p1_out_nxt;
      p1_oe_n_r <= p1_oe_n_nxt;
      p1_pu_r <= p1_dir_r & {8{pullup_r[DGPIO_PU1_BIT]}};
      sck_r <= p1_level[DGPIO_FSEL_PIN2];
      sdi_r <= p1_level[DGPIO_FSEL_PIN3];
    end
  end

  assign reg_rdata = rdata_r;
  assign p0_pin_out = p0_out_r;
  assign p0_pin_oe_n = p0_oe_n_r;
  assign p0_pullup_en = p0_pu_r;
  assign p1_pin_out = p1_out_r;
  assign p1_pin_oe_n = p1_oe_n_r;
  assign p1_pullup_en = p1_pu_r;
  assign serial_shift_clock = sck_r;
  assign serial_data_in = sdi_r;

  // checks
  a_rt_forces_drive: assert property (@(posedge clk_sys) disable iff (rst)
    rt_ctrl_r[DGPIO_RT_LOW_BIT] |=> p0_pin_oe_n[3:0] == 4'h0)
    else $error("realtime low nibble not driven");
  a_rt_write_blocked: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_p0 && !rt_trigger && rt_ctrl_r[DGPIO_RT_HIGH_BIT])
    |=> p0_latch_r[7:4] == $past(p0_latch_r[7:4]))
    else $error("realtime latch changed by cpu write");
  a_latch_holds: assert property (@(posedge clk_sys) disable iff (rst)
    !(reg_wr && reg_addr == DGPIO_OFF_P1_DATA) |=> $stable(p1_latch_r))
    else $error("port 1 latch changed without write");
  a_write_all_bits: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == DGPIO_OFF_P1_DATA) |=> p1_latch_r == $past(reg_wdata))
    else $error("port 1 write lost bits");
  a_input_reads_pin: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_rd && reg_addr == DGPIO_OFF_P0_DATA && rt_ctrl_r == 8'h00 && p0_dir_r == 8'hff)
    |=> reg_rdata == $past(p0_level))
    else $error("input read not pin level");
  a_pullup_gate: assert property (@(posedge clk_sys) disable iff (rst)
    !pullup_r[DGPIO_PU0_BIT] |=> p0_pullup_en == 8'h00)
    else $error("port 0 pullup without option");
  a_ctrl_pin4_out: assert property (@(posedge clk_sys) disable iff (rst)
    p1_ctrl[DGPIO_FSEL_PIN4] |=> !p1_pin_oe_n[4] && p1_pin_out[4] == $past(serial_data_out))
    else $error("pin 4 not carrying serial data");
  a_ctrl_pin3_in: assert property (@(posedge clk_sys) disable iff (rst)
    p1_ctrl[DGPIO_FSEL_PIN3] |=> p1_pin_oe_n[3])
    else $error("pin 3 driven in control mode");
  a_read_idle_zero: assert property (@(posedge clk_sys) disable iff (rst)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  c_rt_trigger: cover property (@(posedge clk_sys) disable iff (rst)
    rt_trigger && rt_ctrl_r == 8'h03);
  c_ctrl_read: cover property (@(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr == DGPIO_OFF_P1_DATA && p1_ctrl != 8'h00);
  c_pullup_on: cover property (@(posedge clk_sys) disable iff (rst)
    p1_pullup_en != 8'h00);
endmodule
`default_nettype wire

// >>> src/dgpio_sync.sv
// dgpio_sync: three-stage synchroniser with agreement filter, eight bits wide
// assumes: inputs are asynchronous pin levels, one system clock
`timescale 1ns/1ps
`default_nettype none
module dgpio_sync
  import dgpio_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // pin side and clean side
  input wire logic [7:0] pin_in,
  output logic [7:0] level_out
);
  logic [7:0] s1_r;
  logic [7:0] s2_r;
  logic [7:0] s3_r;
  logic [7:0] level_r;
  logic [7:0] level_nxt;

  // take a new level only where stage two and three agree
  assign level_nxt = (s2_r & s3_r) | (level_r & (s2_r | s3_r));
  assign level_out = level_r;

  // first stage feeds only the second
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_r <= DGPIO_ZERO_RESET;
      s2_r <= DGPIO_ZERO_RESET;
      s3_r <= DGPIO_ZERO_RESET;
      level_r <= DGPIO_ZERO_RESET;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> verification/dgpio_pads.sv
// dgpio_pads: board pads for one 8-bit port, resolving drive, pullup and
// an outside driver; assumes one system clock for the floating pattern
`timescale 1ns/1ps
`default_nettype none
module dgpio_pads (
  // clock
  input wire logic clk_sys,
  // device side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] pullup_en,
  // board side
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin
);
  logic [7:0] float_r;
  // an undriven pad without pullup toggles so a stale value never passes
  always @(posedge clk_sys) begin
    float_r <= ~float_r;
  end
  initial float_r = 8'h55;
  // device drive wins, then the board, then the pullup
  assign pin = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val) |
               (pin_oe_n & ~ext_en & (pullup_en | float_r));
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// tb_top: register-level tests of the dual gpio port
// assumes: one-cycle read latency, pins settle through dgpio_pads
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dgpio_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rt_trigger = 1'b0;
  logic sck_out = 1'b0, sck_oe = 1'b0, sdo = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, rd, p0_ext_en = 8'h00, p0_ext_val = 8'h00;
  logic [7:0] p1_ext_en = 8'h00, p1_ext_val = 8'h00;
  logic [7:0] p0_in, p0_out, p0_oe_n, p0_pu, p1_in, p1_out, p1_oe_n, p1_pu;
  logic sck_in, sdi;
  int fails = 0, compares = 0;
  always #5 clk_sys = ~clk_sys;
  dgpio_port dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rd), .p0_pin_in(p0_in), .p0_pin_out(p0_out),
    .p0_pin_oe_n(p0_oe_n), .p0_pullup_en(p0_pu), .p1_pin_in(p1_in), .p1_pin_out(p1_out),
    .p1_pin_oe_n(p1_oe_n), .p1_pullup_en(p1_pu), .rt_trigger(rt_trigger),
    .serial_shift_clock_out(sck_out), .serial_shift_clock_oe(sck_oe),
    .serial_data_out(sdo), .serial_shift_clock(sck_in), .serial_data_in(sdi));
  dgpio_pads pads0 (.clk_sys(clk_sys), .pin_out(p0_out), .pin_oe_n(p0_oe_n),
    .pullup_en(p0_pu), .ext_en(p0_ext_en), .ext_val(p0_ext_val), .pin(p0_in));
  dgpio_pads pads1 (.clk_sys(clk_sys), .pin_out(p1_out), .pin_oe_n(p1_oe_n),
    .pullup_en(p1_pu), .ext_en(p1_ext_en), .ext_val(p1_ext_val), .pin(p1_in));
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one-cycle strobes, released at the edge that takes them, one after the edge that sets them
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input string name, input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(name, rd, exp);
  endtask
  // pins follow registers one cycle late, read paths need the synchroniser
  task automatic settle();
    repeat (6) @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse_trigger();
    @(posedge clk_sys);
    rt_trigger <= 1'b1;
    @(posedge clk_sys);
    rt_trigger <= 1'b0;
    settle();
  endtask
  task automatic results();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #200us;
    fails++;
    results();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    // reset state: all pins inputs, control registers at reset values
    #1 chk("p0_oe_n", p0_oe_n, 8'hff);
    chk("p1_oe_n", p1_oe_n, 8'hff);
    rdchk("p0_dir", DGPIO_OFF_P0_DIR, 8'hff);
    rdchk("p1_dir", DGPIO_OFF_P1_DIR, 8'hff);
    rdchk("pullup", DGPIO_OFF_PULLUP, 8'h00);
    $display("test reset done");
    // latch written while input, then half the port turned to output
    p0_ext_en <= 8'hff;
    p0_ext_val <= 8'h3c;
    wr(DGPIO_OFF_P0_DATA, 8'ha5);
    settle();
    chk("p0_oe_n input", p0_oe_n, 8'hff);
    rdchk("p0 pins", DGPIO_OFF_P0_DATA, 8'h3c);
    wr(DGPIO_OFF_P0_DIR, 8'h0f);
    settle();
    chk("p0_oe_n mixed", p0_oe_n, 8'h0f);
    rdchk("p0 mixed", DGPIO_OFF_P0_DATA, 8'hac);
    $display("test port0 direction done");
    // pullups follow the option bits and the input directions only
    wr(DGPIO_OFF_PULLUP, 8'h01);
    settle();
    chk("p0_pu", p0_pu, 8'h0f);
    chk("p1_pu off", p1_pu, 8'h00);
    wr(DGPIO_OFF_PULLUP, 8'hff);
    settle();
    chk("p1_pu", p1_pu, 8'hff);
    rdchk("pullup mask", DGPIO_OFF_PULLUP, 8'h7f);
    $display("test pullup done");
    // low nibble realtime: latch writes there are dropped, trigger loads it
    wr(DGPIO_OFF_RT_CTRL, 8'h01);
    wr(DGPIO_OFF_RT_BUF, 8'hec);
    wr(DGPIO_OFF_P0_DATA, 8'h00);
    settle();
    chk("p0_oe_n rt", p0_oe_n, 8'h00);
    chk("p0_pu rt", p0_pu, 8'h0f);
    rdchk("p0 rt hold", DGPIO_OFF_P0_DATA, 8'h05);
    pulse_trigger();
    rdchk("p0 rt low", DGPIO_OFF_P0_DATA, 8'h0c);
    chk("p0_out rt low", p0_out, 8'h0c);
    wr(DGPIO_OFF_RT_CTRL, 8'hff);
    pulse_trigger();
    chk("p0_out rt byte", p0_out, 8'hec);
    rdchk("rt ctrl", DGPIO_OFF_RT_CTRL, 8'h03);
    // a cpu write to a byte-wide realtime port must leave the latch alone
    wr(DGPIO_OFF_P0_DATA, 8'h00);
    rdchk("p0 rt byte hold", DGPIO_OFF_P0_DATA, 8'hec);
    $display("test realtime done");
    // port 1 pins 2..4 handed to the serial unit, direction ignored for their drive
    p1_ext_en <= 8'hff;
    p1_ext_val <= 8'h08;
    sck_oe <= 1'b1;
    sck_out <= 1'b1;
    wr(DGPIO_OFF_P1_FSEL, 8'hff);
    settle();
    chk("p1_oe_n ctl", p1_oe_n, 8'heb);
    chk("p1_out ctl", p1_out & 8'h14, 8'h04);
    chk("sdi", {7'h00, sdi}, 8'h01);
    chk("sck_in", {7'h00, sck_in}, 8'h01);
    rdchk("p1 pins", DGPIO_OFF_P1_DATA, 8'h0c);
    rdchk("fsel", DGPIO_OFF_P1_FSEL, 8'h1c);
    wr(DGPIO_OFF_P1_DIR, 8'h00);
    settle();
    chk("p1_oe_n out", p1_oe_n, 8'h08);
    rdchk("p1 ctl sig", DGPIO_OFF_P1_DATA, 8'h0c);
    sdo <= 1'b1;
    settle();
    rdchk("p1 ctl sdo", DGPIO_OFF_P1_DATA, 8'h1c);
    // plain port bits keep their latch beside the control pins
    wr(DGPIO_OFF_P1_DATA, 8'h81);
    settle();
    chk("p1_out latch", p1_out & 8'he3, 8'h81);
    rdchk("p1 latch mix", DGPIO_OFF_P1_DATA, 8'h9d);
    // serial unit releases its clock: pin 2 floats back to the board level
    sck_oe <= 1'b0;
    settle();
    chk("p1_oe_n sck in", p1_oe_n, 8'h0c);
    chk("sck_in released", {7'h00, sck_in}, 8'h00);
    $display("test port1 control done");
    // unmapped read, then options cleared before a stop
    rdchk("unmapped", 4'h8, 8'h00);
    wr(DGPIO_OFF_PULLUP, 8'h00);
    settle();
    chk("p1_pu clear", p1_pu, 8'h00);
    $display("test cleanup done");
    results();
  end
endmodule
`default_nettype wire
